// ===== mpr_pkg.sv
// Constants shared by the region protection register block
`default_nettype none
package mpr_pkg;
    // Region storage shape
    localparam int unsigned NUM_REGIONS = 8;
    localparam int unsigned RGN_W       = 3;
    localparam int unsigned BASE_LO     = 5;
    localparam int unsigned BASE_W      = 27;

    // Register byte offsets on the bus
    localparam logic [4:0] OFS_NUMBER   = 5'h00;
    localparam logic [4:0] OFS_BASE     = 5'h04;
    localparam logic [4:0] OFS_ATTR     = 5'h08;
    localparam logic [4:0] OFS_BASE_A1  = 5'h0C;
    localparam logic [4:0] OFS_ATTR_A1  = 5'h10;
    localparam logic [4:0] OFS_BASE_A2  = 5'h14;
    localparam logic [4:0] OFS_ATTR_A2  = 5'h18;

    // Base register fields
    localparam int unsigned VALID_BIT   = 4;
    localparam int unsigned REGION_HI   = 3;

    // Attribute register fields
    localparam int unsigned XN_BIT      = 28;
    localparam int unsigned AP_HI       = 26;
    localparam int unsigned AP_LO       = 24;
    localparam int unsigned TEX_HI      = 21;
    localparam int unsigned TEX_LO      = 19;
    localparam int unsigned S_BIT       = 18;
    localparam int unsigned C_BIT       = 17;
    localparam int unsigned B_BIT       = 16;
    localparam int unsigned SRD_HI      = 15;
    localparam int unsigned SRD_LO      = 8;
    localparam int unsigned SIZE_HI     = 5;
    localparam int unsigned SIZE_LO     = 1;
    localparam int unsigned EN_BIT      = 0;
    localparam logic [31:0] ATTR_MASK   = 32'h173F_FF3F;

    // Size field encodings
    localparam logic [4:0] SIZE_SUB_MIN = 5'h07;
    localparam logic [4:0] SUB_SHIFT    = 5'h02;
    localparam logic [5:0] SIZE_TO_N    = 6'h01;

    // Reset values
    localparam logic [31:0] ATTR_RST    = 32'h0000_0000;
    localparam logic [26:0] BASE_RST    = 27'h000_0000;
    localparam logic [2:0]  RGN_RST     = 3'h0;
endpackage
`default_nettype wire

// ===== mpr_region_match.sv
// Address match of one protection region
`timescale 1ns/1ns
`default_nettype none
module mpr_region_match (
    // Address under check
    input  wire logic [31:0] i_addr,
    // Region settings
    input  wire logic [26:0] i_base,
    input  wire logic [4:0]  i_size,
    input  wire logic [7:0]  i_srd,
    input  wire logic        i_enable,
    // Results
    output logic             o_hit,
    output logic [26:0]      o_base_mask
);
    logic [32:0] span;
    logic [31:0] low;
    logic [31:0] base_full;
    logic [31:0] sub_sel;
    logic        in_range;
    logic        sub_ok;

    // Address bits below N form the offset inside the region
    always_comb begin
        span      = (33'h0_0000_0001 << ({1'b0, i_size} + mpr_pkg::SIZE_TO_N)) - 33'h0_0000_0001;
        low       = span[31:0];
        base_full = {i_base, 5'h00};
        in_range  = ((i_addr ^ base_full) & ~low) == 32'h0000_0000;
    end

    // Readable base bits follow the size
    assign o_base_mask = ~low[31:mpr_pkg::BASE_LO];

    // Subregion index is the top three offset bits
    assign sub_sel = i_addr >> (i_size - mpr_pkg::SUB_SHIFT);
    assign sub_ok  = i_size >= mpr_pkg::SIZE_SUB_MIN;

    // Enabled, in range and subregion not disabled
    assign o_hit = i_enable & in_range & ~(sub_ok & i_srd[sub_sel[2:0]]);
endmodule
`default_nettype wire

// ===== mpr_hit_select.sv
// Priority pick among matching regions
`timescale 1ns/1ns
`default_nettype none
module mpr_hit_select (
    // Per region match
    input  wire logic [7:0] i_hit,
    // Winner
    output logic            o_any,
    output logic [2:0]      o_idx
);
    // Highest numbered matching region wins
    always_comb begin
        o_any = 1'b0;
        o_idx = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (i_hit[i]) begin
                o_any = 1'b1;
                o_idx = 3'(i);
            end
        end
    end
endmodule
`default_nettype wire

// ===== mpr_regions.sv
// Region protection registers, Wishbone slave and access checker
`timescale 1ns/1ns
`default_nettype none
module mpr_regions (
    // Clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_nrst,
    input  wire logic        i_clk_en,
    // Wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [4:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // Access check request
    input  wire logic        i_chk_valid,
    input  wire logic [31:0] i_chk_addr,
    input  wire logic        i_chk_fetch,
    // Access check result
    output logic             o_chk_done,
    output logic             o_chk_hit,
    output logic [2:0]       o_chk_region,
    output logic             o_chk_fetch_block,
    output logic [2:0]       o_chk_ap,
    output logic [2:0]       o_chk_tex,
    output logic             o_chk_s,
    output logic             o_chk_c,
    output logic             o_chk_b,
    // Status
    output logic [2:0]       o_cur_region,
    output logic [7:0]       o_rgn_enabled
);
    //------------------------------------------------------------------
    // Storage
    //------------------------------------------------------------------

    logic [26:0] base_q [8];
    logic [31:0] attr_q [8];
    logic [2:0]  rnum;

    //------------------------------------------------------------------
    // Bus decode
    //------------------------------------------------------------------

    logic        req;
    logic        wr_now;
    logic        sel_word;
    logic        sel_hi;
    logic        sel_lo;
    logic        hit_number;
    logic        hit_base;
    logic        hit_attr;
    logic [2:0]  wr_region;
    logic [31:0] lane_mask;
    logic [31:0] rd_data;

    // Request is cycle and strobe, whether or not an answer is pending
    assign req = i_wb_cyc & i_wb_stb;

    // Write lands on the edge where the master sees ack
    assign wr_now = req & i_wb_we & o_wb_ack;

    // Lane groups
    assign sel_word = i_wb_sel == 4'hF;
    assign sel_hi   = i_wb_sel[3] & i_wb_sel[2];
    assign sel_lo   = i_wb_sel[1] & i_wb_sel[0];

    // Primary and alias addresses share one decode
    assign hit_number = i_wb_adr == mpr_pkg::OFS_NUMBER;
    assign hit_base   = (i_wb_adr == mpr_pkg::OFS_BASE)
                      | (i_wb_adr == mpr_pkg::OFS_BASE_A1)
                      | (i_wb_adr == mpr_pkg::OFS_BASE_A2);
    assign hit_attr   = (i_wb_adr == mpr_pkg::OFS_ATTR)
                      | (i_wb_adr == mpr_pkg::OFS_ATTR_A1)
                      | (i_wb_adr == mpr_pkg::OFS_ATTR_A2);

    // Target of a base write: written field or current number
    assign wr_region = i_wb_dat[mpr_pkg::VALID_BIT] ? i_wb_dat[mpr_pkg::RGN_W-1:0] : rnum;

    // Halfword lanes of the attribute register
    assign lane_mask = {{16{sel_hi}}, {16{sel_lo}}} & mpr_pkg::ATTR_MASK;

    //------------------------------------------------------------------
    // Region matchers
    //------------------------------------------------------------------

    logic [7:0]  rgn_hit;
    logic [26:0] base_mask [8];
    logic        any_hit;
    logic [2:0]  win_idx;

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rgn
            mpr_region_match u_match (
                .i_addr      (i_chk_addr),
                .i_base      (base_q[g]),
                .i_size      (attr_q[g][mpr_pkg::SIZE_HI:mpr_pkg::SIZE_LO]),
                .i_srd       (attr_q[g][mpr_pkg::SRD_HI:mpr_pkg::SRD_LO]),
                .i_enable    (attr_q[g][mpr_pkg::EN_BIT]),
                .o_hit       (rgn_hit[g]),
                .o_base_mask (base_mask[g])
            );
            // Enable flags shown as status
            assign o_rgn_enabled[g] = attr_q[g][mpr_pkg::EN_BIT];
        end
    endgenerate

    // Pick the winning region
    mpr_hit_select u_select (
        .i_hit (rgn_hit),
        .o_any (any_hit),
        .o_idx (win_idx)
    );

    //------------------------------------------------------------------
    // Read mux
    //------------------------------------------------------------------

    // Base reads show masked base, valid zero, current number
    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_number) begin
            rd_data[2:0] = rnum;
        end else if (hit_base) begin
            rd_data[31:mpr_pkg::BASE_LO]   = base_q[rnum] & base_mask[rnum];
            rd_data[mpr_pkg::VALID_BIT]    = 1'b0;
            rd_data[mpr_pkg::REGION_HI:0]  = {1'b0, rnum};
        end else if (hit_attr) begin
            rd_data = attr_q[rnum] & mpr_pkg::ATTR_MASK;
        end
    end

    //------------------------------------------------------------------
    // Bus answer
    //------------------------------------------------------------------

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_wb_ack <= 1'b0;
        end else if (i_clk_en) begin
            o_wb_ack <= req & ~o_wb_ack;
        end
    end

    // Read data captured with the ack
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_wb_dat <= 32'h0000_0000;
        end else if (i_clk_en) begin
            if (req & ~o_wb_ack & ~i_wb_we) begin
                o_wb_dat <= rd_data;
            end else begin
                o_wb_dat <= 32'h0000_0000;
            end
        end
    end

    //------------------------------------------------------------------
    // Region number
    //------------------------------------------------------------------

    // Direct write, or base write with valid set
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            rnum <= mpr_pkg::RGN_RST;
        end else if (i_clk_en && wr_now && sel_word) begin
            if (hit_number) begin
                rnum <= i_wb_dat[mpr_pkg::RGN_W-1:0];
            end else if (hit_base && i_wb_dat[mpr_pkg::VALID_BIT]) begin
                rnum <= i_wb_dat[mpr_pkg::RGN_W-1:0];
            end
        end
    end

    assign o_cur_region = rnum;

    //------------------------------------------------------------------
    // Base storage
    //------------------------------------------------------------------

    // Whole-word base writes go to the chosen region
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < 8; i++) begin
                base_q[i] <= mpr_pkg::BASE_RST;
            end
        end else if (i_clk_en && wr_now && sel_word && hit_base) begin
            base_q[wr_region] <= i_wb_dat[31:mpr_pkg::BASE_LO];
        end
    end

    //------------------------------------------------------------------
    // Attribute storage
    //------------------------------------------------------------------

    // Halfword merge into the selected region
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            for (int i = 0; i < 8; i++) begin
                attr_q[i] <= mpr_pkg::ATTR_RST;
            end
        end else if (i_clk_en && wr_now && hit_attr) begin
            attr_q[rnum] <= (attr_q[rnum] & ~lane_mask) | (i_wb_dat & lane_mask);
        end
    end

    //------------------------------------------------------------------
    // Check result
    //------------------------------------------------------------------

    logic [31:0] win_attr;

    // Attributes of the winning region
    assign win_attr = attr_q[win_idx];

    // Done pulse follows each request
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_chk_done <= 1'b0;
        end else if (i_clk_en) begin
            o_chk_done <= i_chk_valid;
        end
    end

    // Result registered one cycle after the request
    always_ff @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            o_chk_hit         <= 1'b0;
            o_chk_region      <= 3'h0;
            o_chk_fetch_block <= 1'b0;
            o_chk_ap          <= 3'h0;
            o_chk_tex         <= 3'h0;
            o_chk_s           <= 1'b0;
            o_chk_c           <= 1'b0;
            o_chk_b           <= 1'b0;
        end else if (i_clk_en && i_chk_valid) begin
            o_chk_hit         <= any_hit;
            o_chk_region      <= any_hit ? win_idx : 3'h0;
            o_chk_fetch_block <= any_hit & i_chk_fetch & win_attr[mpr_pkg::XN_BIT];
            o_chk_ap          <= any_hit ? win_attr[mpr_pkg::AP_HI:mpr_pkg::AP_LO] : 3'h0;
            o_chk_tex         <= any_hit ? win_attr[mpr_pkg::TEX_HI:mpr_pkg::TEX_LO] : 3'h0;
            o_chk_s           <= any_hit & win_attr[mpr_pkg::S_BIT];
            o_chk_c           <= any_hit & win_attr[mpr_pkg::C_BIT];
            o_chk_b           <= any_hit & win_attr[mpr_pkg::B_BIT];
        end
    end
endmodule
`default_nettype wire

// ===== mpr_regions_assertions.sv
// Timing and field checks on the region protection register block
`timescale 1ns/1ns
`default_nettype none
module mpr_regions_chk (
    // Clock, reset, enable
    input wire logic        i_sys_clk,
    input wire logic        i_nrst,
    input wire logic        i_clk_en,
    // Wishbone slave
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [4:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    // Check port
    input wire logic        i_chk_valid,
    input wire logic        i_chk_fetch,
    input wire logic        o_chk_done,
    input wire logic        o_chk_hit,
    input wire logic [2:0]  o_chk_region,
    input wire logic        o_chk_fetch_block,
    input wire logic [2:0]  o_chk_ap,
    input wire logic [2:0]  o_cur_region
);
    // ------------------------------------------------
    // Decoded bus phases
    // ------------------------------------------------
    logic rd;
    logic wr;
    logic bas;
    logic att;
    assign rd  = o_wb_ack && !i_wb_we;
    assign wr  = o_wb_ack && i_wb_we && i_wb_sel == 4'hF;
    assign bas = i_wb_adr inside {5'h04, 5'h0C, 5'h14};
    assign att = i_wb_adr inside {5'h08, 5'h10, 5'h18};

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_nrst || !i_clk_en);

    // ------------------------------------------------
    // Properties
    // ------------------------------------------------
    ack_single_pulse_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("ack late");
    dat_idle_zero_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data outside ack");
    valid_reads_zero_a: assert property (rd && bas |-> !o_wb_dat[4]) else $error("valid bit read high");
    region_readback_a: assert property (rd && (bas || i_wb_adr == 5'h00) |->
        o_wb_dat[3:0] == {1'b0, o_cur_region}) else $error("region field wrong");
    valid_set_load_a: assert property (wr && bas && i_wb_dat[4] |=>
        o_cur_region == $past(i_wb_dat[2:0])) else $error("region not loaded");
    valid_clear_keep_a: assert property (wr && bas && !i_wb_dat[4] |=> $stable(o_cur_region))
        else $error("region changed");
    attr_reserved_zero_a: assert property (rd && att |-> (o_wb_dat & ~mpr_pkg::ATTR_MASK) == 32'h0)
        else $error("reserved attribute bit read high");
    check_done_a: assert property (i_chk_valid |=> o_chk_done ##1 (o_chk_done == $past(i_chk_valid)))
        else $error("done pulse wrong");
    fetch_block_cause_a: assert property (o_chk_done && o_chk_fetch_block |->
        o_chk_hit && $past(i_chk_fetch)) else $error("fetch blocked without cause");
    miss_results_zero_a: assert property (o_chk_done && !o_chk_hit |->
        o_chk_region == 3'h0 && o_chk_ap == 3'h0 && !o_chk_fetch_block) else $error("miss result not zero");
endmodule

bind mpr_regions mpr_regions_chk i_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_clk_en(i_clk_en),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_chk_valid(i_chk_valid),
    .i_chk_fetch(i_chk_fetch), .o_chk_done(o_chk_done), .o_chk_hit(o_chk_hit), .o_chk_region(o_chk_region),
    .o_chk_fetch_block(o_chk_fetch_block), .o_chk_ap(o_chk_ap), .o_cur_region(o_cur_region));
`default_nettype wire

// ===== mpr_regions_tb_top.sv
// Self-checking bench of the region protection register block
`timescale 1ns/1ns
`default_nettype none
module mpr_regions_tb_top;
    // ------------------------------------------------
    // Signals and model state
    // ------------------------------------------------
    logic        clk, nrst, clk_en, cyc, stb, we, ack, chk_valid, chk_fetch, done, hit, fb, s, c, b;
    logic [2:0]  region, ap, type_extension, cur, m_cur;
    logic [3:0]  sel;
    logic [4:0]  adr;
    logic [7:0]  en8;
    logic [31:0] wdat, rdat, chk_addr;
    logic [31:0] m_base [8];
    logic [31:0] m_attr [8];
    int          n_fail, tests_run, cycles;

    mpr_regions i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_clk_en(clk_en), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_chk_valid(chk_valid), .i_chk_addr(chk_addr), .i_chk_fetch(chk_fetch), .o_chk_done(done),
        .o_chk_hit(hit), .o_chk_region(region), .o_chk_fetch_block(fb), .o_chk_ap(ap), .o_chk_tex(type_extension),
        .o_chk_s(s), .o_chk_c(c), .o_chk_b(b), .o_cur_region(cur), .o_rgn_enabled(en8));

    // Clock and hang guard
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            conclude();
        end
    end

    // ------------------------------------------------
    // Tasks and model
    // ------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] sl, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, sl, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask

    task automatic mwr(input logic [4:0] a, input logic [3:0] sl, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, sl, d, q);
        if (a == 5'h00 && sl == 4'hF) m_cur = d[2:0];
        if (a inside {5'h04, 5'h0C, 5'h14} && sl == 4'hF) begin
            if (d[4]) m_cur = d[2:0];
            m_base[m_cur] = {d[31:5], 5'h00};
        end
        if (a inside {5'h08, 5'h10, 5'h18}) begin
            if (sl[3:2] == 2'b11) m_attr[m_cur][31:16] = d[31:16] & mpr_pkg::ATTR_MASK[31:16];
            if (sl[1:0] == 2'b11) m_attr[m_cur][15:0] = d[15:0] & mpr_pkg::ATTR_MASK[15:0];
        end
    endtask

    function automatic logic [31:0] mrd(input logic [4:0] a);
        logic [31:0] t;
        t = m_attr[m_cur];
        if (a == 5'h00) return {29'h0, m_cur};
        if (a inside {5'h04, 5'h0C, 5'h14}) return (m_base[m_cur] & 32'(~((64'h1 << (t[5:1] + 1)) - 1))) | m_cur;
        if (a inside {5'h08, 5'h10, 5'h18}) return t;
        return 32'h0;
    endfunction

    function automatic logic [13:0] mchk(input logic [31:0] a, input logic f);
        logic [31:0] t;
        logic [13:0] r;
        r = 14'h0;
        for (int i = 0; i < 8; i++) begin
            t = m_attr[i];
            if (t[0] && ((a ^ m_base[i]) & 32'(~((64'h1 << (t[5:1] + 1)) - 1))) == 32'h0 &&
                (t[5:1] < 7 || !t[8 + ((a >> (t[5:1] - 2)) & 7)]))
                r = {1'b1, 3'(i), f & t[28], t[26:24], t[21:19], t[18:16]};
        end
        return r;
    endfunction

    task automatic readall();
        logic [31:0] q;
        logic [7:0]  me;
        for (int a = 0; a < 32; a += 4) begin
            wb(1'b0, 5'(a), 4'hF, 32'h0, q);
            chk("read", q, mrd(5'(a)));
        end
        // Status outputs, settled since the last write
        for (int i = 0; i < 8; i++) me[i] = m_attr[i][0];
        chk("current region", {29'h0, cur}, {29'h0, m_cur});
        chk("region enables", {24'h0, en8}, {24'h0, me});
    endtask

    task automatic probe(input logic [31:0] a, input logic f);
        logic [13:0] e;
        e = mchk(a, f);
        @(posedge clk);
        {chk_valid, chk_addr, chk_fetch} <= {1'b1, a, f};
        @(posedge clk);
        chk_valid <= 1'b0;
        @(posedge clk);
        chk("check", {17'h0, done, hit, region, fb, ap, type_extension, s, c, b}, {17'h0, 1'b1, e});
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------
    // Main sequence
    // ------------------------------------------------
    initial begin
        logic [2:0]  r;
        logic [4:0]  sz, ba;
        logic [31:0] at, bs;
        {clk, nrst, cyc, stb, we, adr, sel, wdat, chk_valid, chk_addr, chk_fetch} = '0;
        {clk_en, m_cur, n_fail, tests_run, cycles} = {1'b1, 3'h0, 96'h0};
        for (int i = 0; i < 8; i++) {m_base[i], m_attr[i]} = 64'h0;
        void'($urandom(32'hB98C530D));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        readall();
        $display("test reset values done");
        for (int n = 0; n < 300; n++) begin
            r = 3'($urandom);
            sz = 5'(4 + $urandom % 28);
            ba = 5'(4 + 8 * ($urandom % 3));
            at = $urandom;
            at[5:1] = sz;
            if (sz < 7) at[15:8] = 8'h00;
            bs = 32'($urandom & ~((64'h1 << (sz + 1)) - 1));
            if (n % 4 == 0) mwr(5'h00, 4'hF, $urandom);
            mwr(ba, 4'hF, bs | 32'h10 | 32'(r));
            if (n % 2 == 1) begin
                mwr(ba + 5'h04, 4'hF, at);
            end else begin
                mwr(ba + 5'h04, 4'h3, at);
                mwr(ba + 5'h04, 4'hC, at);
            end
            if (n % 5 == 0) mwr(ba + 5'h04, 4'h2, $urandom);
            if (n % 7 == 0) mwr(ba, 4'hF, bs | ($urandom & 32'hF));
            readall();
            probe($urandom, 1'($urandom));
            probe(bs | 32'($urandom & ((64'h1 << (sz + 1)) - 1)), 1'($urandom));
        end
        $display("test random programming done");
        // Clock enable low holds the check port, then a mid-run reset clears all
        @(posedge clk);
        {clk_en, chk_valid, chk_addr} <= {1'b0, 1'b1, 32'h0000_0000};
        repeat (2) @(posedge clk);
        chk("frozen done", {31'h0, done}, 32'h0);
        {clk_en, chk_valid, nrst} <= 3'b100;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        m_cur = 3'h0;
        for (int i = 0; i < 8; i++) {m_base[i], m_attr[i]} = 64'h0;
        readall();
        probe(32'h0000_0000, 1'b1);
        $display("test freeze and reset done");
        conclude();
    end
endmodule
`default_nettype wire
